// File: pkg/bmfa_pkg.sv
// boot memory map and flash access: shared constants, states, helpers
// assumes a single 10 MHz system clock and active-low async reset
package bmfa_pkg;
  localparam logic [31:0] SRAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] BB_BASE    = 32'h2200_0000;
  localparam logic [31:0] BB_LAST    = 32'h23ff_ffff;
  localparam logic [31:0] ROM_BASE   = 32'h0080_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0040_0000;
  localparam logic [31:0] BOOT_BASE  = 32'h0000_0000;

  localparam int PAGE_BYTES  = 256;
  localparam int PAGES_MAX   = 1024;
  localparam int WBUF_BYTES  = 128;
  localparam int WBUF_WORDS  = WBUF_BYTES / 4;
  localparam int WBUF_AW     = 5;
  localparam int LOCK_SHIFT  = 6;
  localparam int LOCK_COUNT  = 16;

  localparam int          NV_COUNT    = 3;
  localparam int          NV_SECURITY = 0;
  localparam int          NV_BOOT     = 1;
  localparam logic [2:0]  NV_RESET    = 3'h0;
  localparam logic [15:0] LOCK_RESET  = 16'h0000;
  // arbitrary identity value, names no real part
  localparam logic [31:0] FLASH_ID    = 32'h0000_a5c3;

  localparam logic [7:0] CMD_GET_DESC   = 8'h00;
  localparam logic [7:0] CMD_WRITE_PAGE = 8'h01;
  localparam logic [7:0] CMD_ERASE_WR   = 8'h03;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h05;
  localparam logic [7:0] CMD_LOCK       = 8'h08;
  localparam logic [7:0] CMD_UNLOCK     = 8'h09;
  localparam logic [7:0] CMD_SET_NV     = 8'h0b;
  localparam logic [7:0] CMD_CLR_NV     = 8'h0c;
  localparam logic [7:0] CMD_GET_NV     = 8'h0d;
  localparam logic [7:0] CMD_READ       = 8'h10;
  localparam logic [7:0] CMD_PROTECT    = 8'h11;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_MISS = 3'h2,
    BUS_FILL = 3'h4
  } bmfa_bus_t;

  typedef enum logic [3:0] {
    CMD_IDLE  = 4'h1,
    CMD_ARRAY = 4'h2,
    CMD_RDREQ = 4'h4,
    CMD_RDCAP = 4'h8
  } bmfa_cmd_t;

  function automatic logic [14:0] ram_bytes(input logic [1:0] fuse);
    case (fuse)
      2'h0:    ram_bytes = 15'h2000;
      2'h1:    ram_bytes = 15'h4000;
      default: ram_bytes = 15'h6000;
    endcase
  endfunction : ram_bytes

  function automatic logic [10:0] flash_pages(input logic [1:0] variant);
    case (variant)
      2'h0:    flash_pages = 11'h100;
      2'h1:    flash_pages = 11'h200;
      default: flash_pages = 11'h400;
    endcase
  endfunction : flash_pages
endpackage : bmfa_pkg

// File: sim/bmfa_flash_model.sv
// flash macro stand-in: line reads and timed program or erase
// assumes registered array_rd and array_start from the controller
module bmfa_flash_model (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         array_rd,
  input  wire logic [17:0]  array_addr,
  output logic      [127:0] array_rdata,
  input  wire logic         array_start,
  output logic              array_done,
  output logic      [4:0]   buf_rd_addr,
  input  wire logic [31:0]  buf_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0]   cnt;
  logic [127:0] junk;
  // line valid only while array_rd stands, scrambled otherwise, so a
  // capture in any other cycle shows up as a mismatch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      junk <= 128'h0;
    end else begin
      junk <= ~junk;
    end
  end
  always_comb begin
    array_rdata = junk;
    if (array_rd) begin
      for (int k = 0; k < 4; k++) begin
        array_rdata[32*k+:32] = {array_addr[17:4], k[1:0], 16'ha5c0};
      end
    end
  end
  // walks all buffer words, slow on purpose to stall the bus
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 6'h0;
      array_done <= 1'b0;
      buf_rd_addr <= 5'h0;
    end else begin
      array_done <= (cnt == 6'h21);
      buf_rd_addr <= cnt[4:0];
      if (array_start) cnt <= 6'h1;
      else if (cnt != 6'h0 && cnt != 6'h21) cnt <= cnt + 6'h1;
      else cnt <= 6'h0;
    end
  end
endmodule : bmfa_flash_model

// File: sim/bmfa_top_tb.sv
// self-checking bench for the boot map and flash controller
// assumes the flash model stands in for the array macro
module bmfa_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, bus_req, bus_write, bus_ack, bus_err;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, buf_rd_data, cmd_result;
  logic sram_sel, sram_bit_mode, rom_sel, wide_mode, array_rd;
  logic [2:0] sram_bit_idx, nv_stored, general_nonvolatile_bits;
  logic [14:0] sram_offset;
  logic [21:0] rom_offset;
  logic [1:0] ram_size_fuse, flash_variant;
  logic array_half, array_start, array_done, cmd_valid, fpp_cmd_valid;
  logic [17:0] array_addr;
  logic [127:0] array_rdata;
  logic [7:0] array_op, cmd_code, fpp_cmd_code;
  logic [9:0] array_page;
  logic [4:0] buf_rd_addr;
  logic [15:0] cmd_arg, fpp_cmd_arg;
  logic test_mode_pin, port_a_line_zero, port_a_line_one, fpp_mode;
  logic cmd_busy, cmd_done, cmd_error, erase_pin, nv_write;
  logic boot_ready, boot_from_flash;
  logic [35:0] exp_q[$];
  logic [35:0] obs;
  logic [31:0] off;
  int mismatches, checked;

  bmfa_top dut_u (.*);
  bmfa_flash_model flash_u (.*);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [35:0] e, input logic [35:0] o);
    checked++;
    if (e !== o) begin
      mismatches++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, o);
    end
  endtask : chk

  task automatic finish_test();
    $display("counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // bounded wait until the monitor has consumed every note
  task automatic settle();
    for (int i = 0; i < 80 && exp_q.size() != 0; i++) @(posedge mclk);
    if (exp_q.size() != 0) begin
      mismatches++;
      finish_test();
    end
  endtask : settle

  // one-cycle request: the engine is idle here, so it is taken
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [35:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    bus_req <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_wdata <= $urandom;
    @(posedge mclk);
    bus_req <= 1'b0;
    settle();
  endtask : bus

  task automatic cmd(input logic [7:0] c, input logic [15:0] a,
                     input logic er);
    exp_q.push_back({4'h4, 31'h0, er});
    @(posedge mclk);
    if (fpp_mode === 1'b1) begin
      fpp_cmd_valid <= 1'b1;
      fpp_cmd_code <= c;
      fpp_cmd_arg <= a;
    end else begin
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_arg <= a;
    end
    @(posedge mclk);
    cmd_valid <= 1'b0;
    fpp_cmd_valid <= 1'b0;
    settle();
  endtask : cmd

  task automatic do_reset(input logic [2:0] nv);
    nv_stored <= nv;
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  always @(posedge mclk) begin
    if (reset_n === 1'b1 &&
        (bus_ack | sram_sel | rom_sel | cmd_done) === 1'b1) begin
      obs = bus_ack ? {3'h1, bus_err, bus_rdata} :
            sram_sel ? {4'h2, sram_bit_mode, sram_bit_idx, 13'h0,
                        sram_offset} :
            rom_sel ? {4'h3, 10'h0, rom_offset} :
            {4'h4, 31'h0, cmd_error};
      if (exp_q.size() == 0) chk(36'h0, obs);
      else chk(exp_q.pop_front(), obs);
    end
  end

  initial begin
    void'($urandom(32'hd060));
    {reset_n, bus_req, bus_write, cmd_valid, fpp_cmd_valid} = 5'h0;
    {bus_addr, bus_wdata, cmd_code, cmd_arg} = 88'h0;
    {fpp_cmd_code, fpp_cmd_arg, erase_pin} = 25'h0;
    {test_mode_pin, port_a_line_zero, port_a_line_one} = 3'h7;
    {ram_size_fuse, flash_variant, wide_mode} = 5'h4;
    nv_stored = 3'h2;
    do_reset(3'h2);
    chk({34'h0, boot_ready, boot_from_flash}, 36'h3);
    chk({33'h0, general_nonvolatile_bits}, 36'h2);
    off = $urandom & 32'h1ffc;
    bus(1'b0, 32'h2000_0000 + off, {9'h40, 12'h0, off[14:0]});
    bus(1'b0, 32'h2200_0024, {4'h2, 1'b1, 3'h1, 28'h1});
    bus(1'b1, 32'h2000_2000, {3'h1, 1'b1, 32'h0});
    bus(1'b0, 32'h0080_0004, {4'h3, 32'h4});
    bus(1'b1, 32'h0080_0004, {3'h1, 1'b1, 32'h0});
    $display("map test done");
    for (int n = 0; n < 4; n++) begin
      wide_mode <= n[0];
      off = $urandom & 32'h3fffc;
      bus(1'b0, (n > 1 ? 32'h0 : bmfa_pkg::FLASH_BASE) + off,
          {4'h2, off[17:4], off[3:2], 16'ha5c0});
      chk({17'h0, array_half, array_addr},
          {17'h0, off[3], off[17:4], 4'h0});
    end
    bus(1'b0, bmfa_pkg::FLASH_BASE + (off ^ 32'h4),
        {4'h2, off[17:4], off[3:2] ^ 2'h1, 16'ha5c0});
    bus(1'b1, bmfa_pkg::FLASH_BASE + 32'h8, 36'h2_0000_0000);
    cmd(bmfa_pkg::CMD_WRITE_PAGE, 16'h5, 1'b0);
    chk({18'h0, array_op, array_page},
        {18'h0, bmfa_pkg::CMD_WRITE_PAGE, 10'h5});
    cmd(bmfa_pkg::CMD_LOCK, 16'h0, 1'b0);
    cmd(bmfa_pkg::CMD_WRITE_PAGE, 16'h3f, 1'b1);
    cmd(bmfa_pkg::CMD_UNLOCK, 16'h0, 1'b0);
    cmd(bmfa_pkg::CMD_ERASE_ALL, 16'h0, 1'b0);
    cmd(bmfa_pkg::CMD_GET_DESC, 16'h3, 1'b0);
    chk({4'h0, cmd_result}, 36'h400);
    cmd(8'hee, 16'h0, 1'b1);
    $display("flash test done");
    cmd(bmfa_pkg::CMD_CLR_NV, 16'h1, 1'b0);
    chk({33'h0, general_nonvolatile_bits}, 36'h0);
    cmd(bmfa_pkg::CMD_SET_NV, 16'h1, 1'b0);
    erase_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    erase_pin <= 1'b0;
    chk({33'h0, general_nonvolatile_bits}, 36'h0);
    do_reset(3'h0);
    chk({35'h0, boot_from_flash}, 36'h0);
    bus(1'b0, 32'h0000_0004, {4'h3, 32'h4});
    $display("boot test done");
    {test_mode_pin, port_a_line_zero, port_a_line_one} <= 3'h0;
    repeat (3) @(posedge mclk);
    chk({35'h0, fpp_mode}, 36'h1);
    off = $urandom;
    cmd(bmfa_pkg::CMD_READ, off[15:0], 1'b0);
    chk({4'h0, cmd_result}, {4'h0, off[15:0], 16'ha5c0});
    cmd(bmfa_pkg::CMD_WRITE_PAGE, 16'h1, 1'b0);
    cmd(bmfa_pkg::CMD_ERASE_WR, 16'h2, 1'b0);
    cmd(bmfa_pkg::CMD_ERASE_ALL, 16'h0, 1'b0);
    cmd(bmfa_pkg::CMD_LOCK, 16'h40, 1'b0);
    cmd(bmfa_pkg::CMD_UNLOCK, 16'h40, 1'b0);
    cmd(bmfa_pkg::CMD_PROTECT, 16'h0, 1'b0);
    chk({33'h0, general_nonvolatile_bits}, 36'h1);
    cmd(bmfa_pkg::CMD_READ, 16'h0, 1'b1);
    $display("fast port test done");
    finish_test();
  end
endmodule : bmfa_top_tb

// File: src/bmfa_top.sv
// boot memory map, flash access controller and fast programming entry
// assumes synchronous inputs on mclk; sram, rom and the flash macro
// sit outside and answer on their own ports
module bmfa_top (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          bus_req,
  input  wire logic          bus_write,
  input  wire logic [31:0]   bus_addr,
  input  wire logic [31:0]   bus_wdata,
  output logic               bus_ack,
  output logic               bus_err,
  output logic      [31:0]   bus_rdata,
  output logic               sram_sel,
  output logic               sram_bit_mode,
  output logic      [2:0]    sram_bit_idx,
  output logic      [14:0]   sram_offset,
  output logic               rom_sel,
  output logic      [21:0]   rom_offset,
  input  wire logic [1:0]    ram_size_fuse,
  input  wire logic [1:0]    flash_variant,
  input  wire logic          wide_mode,
  output logic               array_rd,
  output logic               array_half,
  output logic      [17:0]   array_addr,
  input  wire logic [127:0]  array_rdata,
  output logic               array_start,
  output logic      [7:0]    array_op,
  output logic      [9:0]    array_page,
  input  wire logic          array_done,
  input  wire logic [4:0]    buf_rd_addr,
  output logic      [31:0]   buf_rd_data,
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_code,
  input  wire logic [15:0]   cmd_arg,
  input  wire logic          test_mode_pin,
  input  wire logic          port_a_line_zero,
  input  wire logic          port_a_line_one,
  input  wire logic          fpp_cmd_valid,
  input  wire logic [7:0]    fpp_cmd_code,
  input  wire logic [15:0]   fpp_cmd_arg,
  output logic               fpp_mode,
  output logic               cmd_busy,
  output logic               cmd_done,
  output logic               cmd_error,
  output logic      [31:0]   cmd_result,
  input  wire logic [2:0]    nv_stored,
  input  wire logic          erase_pin,
  output logic      [2:0]    general_nonvolatile_bits,
  output logic               nv_write,
  output logic               boot_ready,
  output logic               boot_from_flash
);
  bmfa_pkg::bmfa_bus_t bus_state;
  bmfa_pkg::bmfa_cmd_t cmd_state;
  logic          nv_loaded;
  logic [2:0]    next_nv;
  logic [15:0]   lock_bits;
  logic [127:0]  line_data;
  logic [17:3]   line_addr;
  logic          line_wide;
  logic          line_valid;
  logic [17:0]   pend_off;
  logic [15:0]   rd_word;
  logic          bus_take;
  logic          in_boot;
  logic          is_sram;
  logic          is_bb;
  logic          is_rom;
  logic          is_flash;
  logic          dec_err;
  logic          line_hit;
  logic [14:0]   ram_lim;
  logic [10:0]   pages;
  logic          src_valid;
  logic [7:0]    src_code;
  logic [15:0]   src_arg;
  logic          cmd_take;
  logic          page_ok;
  logic          fpp_entry;

  // word select inside a fetched line
  function automatic logic [31:0] pick(input logic [127:0] l,
                                       input logic [1:0] w);
    pick = l[{w, 5'h00} +: 32];
  endfunction : pick

  assign ram_lim  = bmfa_pkg::ram_bytes(ram_size_fuse);
  assign pages    = bmfa_pkg::flash_pages(flash_variant);
  assign bus_take = bus_req && bus_state == bmfa_pkg::BUS_IDLE
                    && nv_loaded;
  assign fpp_entry = !test_mode_pin && !port_a_line_zero
                     && !port_a_line_one;

  always_comb begin
    in_boot  = bus_addr[31:22] == bmfa_pkg::BOOT_BASE[31:22];
    is_sram  = bus_addr[31:25] == bmfa_pkg::SRAM_BASE[31:25]
               && bus_addr[24:15] == 10'h000
               && bus_addr[14:0] < ram_lim;
    is_bb    = bus_addr[31:25] == bmfa_pkg::BB_BASE[31:25]
               && bus_addr[24:20] == 5'h00
               && bus_addr[19:5] < ram_lim;
    is_rom   = !bus_write && (bus_addr[31:22] == bmfa_pkg::ROM_BASE[31:22]
               || (in_boot && !boot_from_flash));
    is_flash = (bus_addr[31:22] == bmfa_pkg::FLASH_BASE[31:22]
               || (in_boot && boot_from_flash))
               && bus_addr[21:18] == 4'h0
               && {1'b0, bus_addr[17:8]} < pages;
    dec_err  = !(is_sram || is_bb || is_rom || is_flash);
    line_hit = line_valid && line_addr[17:4] == bus_addr[17:4]
               && (line_wide || line_addr[3] == bus_addr[3]);
  end

  // fast port owns the command engine while strapped
  always_comb begin
    src_valid = fpp_mode ? fpp_cmd_valid : cmd_valid;
    src_code  = fpp_mode ? fpp_cmd_code : cmd_code;
    src_arg   = fpp_mode ? fpp_cmd_arg : cmd_arg;
    cmd_take  = src_valid && cmd_state == bmfa_pkg::CMD_IDLE
                && nv_loaded && bus_state == bmfa_pkg::BUS_IDLE;
    page_ok   = src_arg[15:10] == 6'h00 && {1'b0, src_arg[9:0]} < pages;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fpp_mode <= 1'b0;
    end else begin
      fpp_mode <= fpp_entry;
    end
  end

  bmfa_wbuf u_wbuf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wr_en   (bus_take && is_flash && bus_write),
    .wr_addr (bus_addr[6:2]),
    .wr_data (bus_wdata),
    .rd_addr (buf_rd_addr),
    .rd_data (buf_rd_data)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state     <= bmfa_pkg::BUS_IDLE;
      bus_ack       <= 1'b0;
      bus_err       <= 1'b0;
      bus_rdata     <= 32'h0000_0000;
      sram_sel      <= 1'b0;
      sram_bit_mode <= 1'b0;
      sram_bit_idx  <= 3'h0;
      sram_offset   <= 15'h0000;
      rom_sel       <= 1'b0;
      rom_offset    <= 22'h00_0000;
      pend_off      <= 18'h0_0000;
    end else begin
      bus_ack  <= 1'b0;
      bus_err  <= 1'b0;
      sram_sel <= 1'b0;
      rom_sel  <= 1'b0;
      case (bus_state)
        bmfa_pkg::BUS_IDLE: begin
          if (bus_take) begin
            if (dec_err) begin
              bus_err <= 1'b1;
              bus_ack <= 1'b1;
            end else if (is_sram || is_bb) begin
              sram_sel      <= 1'b1;
              sram_bit_mode <= is_bb;
              sram_bit_idx  <= is_bb ? bus_addr[4:2] : 3'h0;
              sram_offset   <= is_bb ? bus_addr[19:5] : bus_addr[14:0];
            end else if (is_rom) begin
              rom_sel    <= 1'b1;
              rom_offset <= bus_addr[21:0];
            end else if (bus_write || line_hit) begin
              bus_ack   <= 1'b1;
              bus_rdata <= bus_write ? 32'h0000_0000
                           : pick(line_data, bus_addr[3:2]);
            end else begin
              pend_off  <= bus_addr[17:0];
              bus_state <= bmfa_pkg::BUS_MISS;
            end
          end
        end
        bmfa_pkg::BUS_MISS: begin
          if (cmd_state == bmfa_pkg::CMD_IDLE) begin
            bus_state <= bmfa_pkg::BUS_FILL;
          end
        end
        bmfa_pkg::BUS_FILL: begin
          bus_ack   <= 1'b1;
          bus_rdata <= pick(array_rdata, pend_off[3:2]);
          bus_state <= bmfa_pkg::BUS_IDLE;
        end
        default: bus_state <= bmfa_pkg::BUS_IDLE;
      endcase
    end
  end

  // array reads: bus misses and CMD_READ commands from either port share the port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      array_rd   <= 1'b0;
      array_half <= 1'b0;
      array_addr <= 18'h0_0000;
    end else begin
      array_rd <= 1'b0;
      if (bus_state == bmfa_pkg::BUS_MISS
          && cmd_state == bmfa_pkg::CMD_IDLE) begin
        array_rd   <= 1'b1;
        array_half <= pend_off[3];
        array_addr <= {pend_off[17:4], 4'h0};
      end else if (cmd_state == bmfa_pkg::CMD_RDREQ) begin
        array_rd   <= 1'b1;
        array_half <= rd_word[1];
        array_addr <= {rd_word[15:2], 4'h0};
      end
    end
  end

  // line is dropped when an array operation starts: stale after program
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      line_valid <= 1'b0;
      line_wide  <= 1'b0;
      line_addr  <= 15'h0000;
      line_data  <= 128'h0;
    end else if (bus_state == bmfa_pkg::BUS_FILL) begin
      line_valid <= 1'b1;
      line_wide  <= wide_mode;
      line_addr  <= pend_off[17:3];
      line_data  <= array_rdata;
    end else if (array_start) begin
      line_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_state   <= bmfa_pkg::CMD_IDLE;
      cmd_busy    <= 1'b0;
      cmd_done    <= 1'b0;
      cmd_error   <= 1'b0;
      cmd_result  <= 32'h0000_0000;
      lock_bits   <= bmfa_pkg::LOCK_RESET;
      array_start <= 1'b0;
      array_op    <= 8'h00;
      array_page  <= 10'h000;
      rd_word     <= 16'h0000;
    end else begin
      cmd_done    <= 1'b0;
      array_start <= 1'b0;
      case (cmd_state)
        bmfa_pkg::CMD_IDLE: begin
          if (cmd_take) begin
            cmd_done  <= 1'b1;
            cmd_error <= 1'b0;
            case (src_code)
              bmfa_pkg::CMD_GET_DESC: begin
                case (src_arg[1:0])
                  2'h0:    cmd_result <= bmfa_pkg::FLASH_ID;
                  2'h1:    cmd_result <= {13'h0000, pages, 8'h00};
                  2'h2:    cmd_result <= 32'(bmfa_pkg::PAGE_BYTES);
                  default: cmd_result <= {21'h00_0000, pages};
                endcase
              end
              bmfa_pkg::CMD_WRITE_PAGE, bmfa_pkg::CMD_ERASE_WR,
              bmfa_pkg::CMD_ERASE_ALL: begin
                if (src_code == bmfa_pkg::CMD_ERASE_ALL ? |lock_bits
                    : (!page_ok || lock_bits[src_arg[9:6]])) begin
                  cmd_error <= 1'b1;
                end else begin
                  cmd_done    <= 1'b0;
                  cmd_busy    <= 1'b1;
                  array_start <= 1'b1;
                  array_op    <= src_code;
                  array_page  <= src_arg[9:0];
                  cmd_state   <= bmfa_pkg::CMD_ARRAY;
                end
              end
              bmfa_pkg::CMD_LOCK, bmfa_pkg::CMD_UNLOCK: begin
                if (!page_ok) begin
                  cmd_error <= 1'b1;
                end else begin
                  lock_bits[src_arg[9:6]] <=
                    src_code == bmfa_pkg::CMD_LOCK;
                end
              end
              bmfa_pkg::CMD_SET_NV, bmfa_pkg::CMD_CLR_NV: begin
                cmd_error <= src_arg > 16'(bmfa_pkg::NV_COUNT - 1);
              end
              bmfa_pkg::CMD_GET_NV: begin
                cmd_result <= {29'h0000_0000, general_nonvolatile_bits};
              end
              bmfa_pkg::CMD_PROTECT: begin
                cmd_result <= 32'h0000_0000;
              end
              bmfa_pkg::CMD_READ: begin
                if ((fpp_mode && general_nonvolatile_bits[0])
                    || {1'b0, src_arg[15:6]} >= pages) begin
                  cmd_error <= 1'b1;
                end else begin
                  cmd_done  <= 1'b0;
                  cmd_busy  <= 1'b1;
                  rd_word   <= src_arg;
                  cmd_state <= bmfa_pkg::CMD_RDREQ;
                end
              end
              default: cmd_error <= 1'b1;
            endcase
          end
        end
        bmfa_pkg::CMD_ARRAY: begin
          if (array_done) begin
            cmd_done  <= 1'b1;
            cmd_busy  <= 1'b0;
            cmd_state <= bmfa_pkg::CMD_IDLE;
          end
        end
        bmfa_pkg::CMD_RDREQ: cmd_state <= bmfa_pkg::CMD_RDCAP;
        bmfa_pkg::CMD_RDCAP: begin
          cmd_result <= pick(array_rdata, rd_word[1:0]);
          cmd_done   <= 1'b1;
          cmd_busy   <= 1'b0;
          cmd_state  <= bmfa_pkg::CMD_IDLE;
        end
        default: cmd_state <= bmfa_pkg::CMD_IDLE;
      endcase
    end
  end

  // erase pin applied last so it wins over a set command
  always_comb begin
    next_nv = general_nonvolatile_bits;
    if (cmd_take && src_arg < 16'(bmfa_pkg::NV_COUNT)) begin
      if (src_code == bmfa_pkg::CMD_SET_NV) begin
        next_nv[src_arg[1:0]] = 1'b1;
      end else if (src_code == bmfa_pkg::CMD_CLR_NV) begin
        next_nv[src_arg[1:0]] = 1'b0;
      end
    end
    if (cmd_take && src_code == bmfa_pkg::CMD_PROTECT) begin
      next_nv[bmfa_pkg::NV_SECURITY] = 1'b1;
    end
    if (erase_pin) begin
      next_nv[bmfa_pkg::NV_BOOT] = 1'b0;
    end
  end

  // boot map latched once per reset; later changes apply next boot
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nv_loaded                <= 1'b0;
      general_nonvolatile_bits <= bmfa_pkg::NV_RESET;
      nv_write                 <= 1'b0;
      boot_ready               <= 1'b0;
      boot_from_flash          <= 1'b0;
    end else if (!nv_loaded) begin
      nv_loaded                <= 1'b1;
      boot_ready               <= 1'b1;
      general_nonvolatile_bits <= nv_stored;
      boot_from_flash          <= nv_stored[bmfa_pkg::NV_BOOT];
    end else begin
      nv_write                 <= next_nv != general_nonvolatile_bits;
      general_nonvolatile_bits <= next_nv;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_sram_base: assert property (bus_take && bus_addr == 32'h2000_0000
    |=> sram_sel && sram_offset == 15'h0000 && !sram_bit_mode)
    else $error("sram base not decoded");
  a_bitband_map: assert property (bus_take && bus_addr == 32'h2200_0024
    |=> sram_sel && sram_bit_mode && sram_offset == 15'h0001
        && sram_bit_idx == 3'h1)
    else $error("bit-band alias mapped wrong");
  a_ram_limit: assert property (bus_take
    && bus_addr == {17'h0_4000, ram_lim} |=> bus_err && bus_ack)
    else $error("sram beyond fused size accepted");
  a_rom_fixed: assert property (bus_take && !bus_write
    && bus_addr[31:22] == 10'h002 |=> rom_sel
    && rom_offset == $past(bus_addr[21:0]))
    else $error("rom window not decoded");
  a_boot_select: assert property (bus_take && !bus_write
    && bus_addr[31:22] == 10'h000 |=> rom_sel == !boot_from_flash)
    else $error("boot address mapped to wrong memory");
  a_miss_fetch: assert property (bus_state == bmfa_pkg::BUS_MISS
    && cmd_state == bmfa_pkg::CMD_IDLE |=> array_rd ##1 bus_ack)
    else $error("flash miss not fetched and answered");
  a_lock_refuse: assert property (cmd_take
    && src_code == bmfa_pkg::CMD_WRITE_PAGE && lock_bits[src_arg[9:6]]
    |=> cmd_done && cmd_error && !array_start && !cmd_busy)
    else $error("locked page programmed");
  a_secure_read: assert property (cmd_take && fpp_mode
    && src_code == bmfa_pkg::CMD_READ && general_nonvolatile_bits[0]
    |=> cmd_error && cmd_done)
    else $error("secured read allowed");
  a_fpp_entry: assert property (fpp_entry [*2] |=> fpp_mode)
    else $error("fast programming not entered");
  a_erase_clear: assert property (nv_loaded && erase_pin
    |=> !general_nonvolatile_bits[bmfa_pkg::NV_BOOT])
    else $error("erase pin left boot bit set");
  a_nv_sample: assert property (reset_n && !nv_loaded |=> boot_ready
    && general_nonvolatile_bits == $past(nv_stored))
    else $error("nonvolatile bits not sampled at boot");

  c_bitband: cover property (bus_take && is_bb);
  c_flash_boot: cover property (bus_take && in_boot && boot_from_flash);
  c_page_prog: cover property (cmd_state == bmfa_pkg::CMD_ARRAY
    && array_done);
  c_fpp_read: cover property (fpp_mode && cmd_state == bmfa_pkg::CMD_RDCAP);
endmodule : bmfa_top

// File: src/bmfa_wbuf.sv
// flash write buffer: 32 words of 32 bits, one write and one read port
// assumes writer and reader share mclk; read data is registered
module bmfa_wbuf (
  input  wire logic                            mclk,
  input  wire logic                            reset_n,
  input  wire logic                            wr_en,
  input  wire logic [bmfa_pkg::WBUF_AW-1:0]    wr_addr,
  input  wire logic [31:0]                     wr_data,
  input  wire logic [bmfa_pkg::WBUF_AW-1:0]    rd_addr,
  output logic      [31:0]                     rd_data
);
  logic [31:0] mem [bmfa_pkg::WBUF_WORDS];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : bmfa_wbuf
